// [rtl/fadd_pkg.sv]
// constants and types shared by the float align/divide datapath
package fadd_pkg;

  // word and field widths
  localparam int MW = 36;
  localparam int SW = 9;
  localparam int HW = 18;
  localparam int DW = 32;
  localparam int AW = 8;

  // bit positions, numbered from the low end of the 36-bit word
  localparam int TOP_BIT = 35;
  localparam int LEAD_BIT = 34;
  localparam int HALF_SIGN = 17;

  // arithmetic constants
  localparam logic [MW-1:0] MANT_ZERO = 36'h0_0000_0000;
  localparam logic [MW-1:0] MANT_ONE = 36'h0_0000_0001;
  localparam logic [SW-1:0] SCALE_ZERO = 9'h000;
  localparam logic [SW-1:0] SCALE_ONE = 9'h001;
  localparam logic [SW:0] GAP_LIMIT = 10'h023;
  localparam logic [SW-1:0] NORM_PRELOAD = 9'h023;
  localparam logic [SW-1:0] DIV_STEPS = 9'h024;

  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_STAT = 8'h04;
  localparam logic [AW-1:0] OFS_MAHI = 8'h08;
  localparam logic [AW-1:0] OFS_MALO = 8'h0C;
  localparam logic [AW-1:0] OFS_MBHI = 8'h10;
  localparam logic [AW-1:0] OFS_MBLO = 8'h14;
  localparam logic [AW-1:0] OFS_MQHI = 8'h18;
  localparam logic [AW-1:0] OFS_MQLO = 8'h1C;
  localparam logic [AW-1:0] OFS_SCALE = 8'h20;
  localparam logic [AW-1:0] OFS_SIGN = 8'h24;
  localparam logic [AW-1:0] OFS_BUFHI = 8'h28;
  localparam logic [AW-1:0] OFS_BUFLO = 8'h2C;

  // register fields
  localparam int CTL_OP_LSB = 0;
  localparam int CTL_OP_MSB = 2;
  localparam int CTL_SINGLE = 3;
  localparam int CTL_ABORT = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FLAGS_LSB = 1;
  localparam int SC_A_LSB = 0;
  localparam int SC_B_LSB = 16;
  localparam int SG_A = 0;
  localparam int SG_B = 1;

  // bus encodings
  localparam logic [2:0] SIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_ADD = 3'h1,
    OP_SUB = 3'h2,
    OP_DIV = 3'h3,
    OP_IDIV = 3'h4,
    OP_LDINT = 3'h5,
    OP_LDFLT = 3'h6,
    OP_NORM = 3'h7
  } fadd_op_t;

  // gray steps along idle, exponent, function, normalize
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_EXP = 3'h1,
    ST_FUN = 3'h3,
    ST_NOR = 3'h2,
    ST_DVEND = 3'h6,
    ST_DVSWP = 3'h7
  } fadd_state_t;

  typedef struct packed {
    logic phaseAborted;
    logic leadingOneFound;
    logic divZero;
    logic zeroResultClear;
    logic carryScaleBump;
    logic subOverflow;
    logic scaleGapException;
    logic aOverBLimit;
    logic bOverALimit;
    logic shiftBForMatch;
    logic shiftAForMatch;
    logic unlikeAdd;
    logic likeAdd;
  } fadd_flags_t;

  typedef struct packed {
    logic aLess;
    logic bLess;
    logic bOverALimit;
    logic aOverBLimit;
    logic [SW-1:0] gap;
  } fadd_cmp_t;

  typedef struct packed {
    fadd_state_t state;
    fadd_op_t op;
    logic single;
    logic first;
    logic [MW-1:0] mantA;
    logic [MW-1:0] mantB;
    logic [MW-1:0] quot;
    logic [SW-1:0] scaleA;
    logic [SW-1:0] scaleB;
    logic signA;
    logic signB;
    logic [MW-1:0] membuf;
    logic [SW-1:0] cnt;
    fadd_flags_t flags;
    logic dpWrite;
    logic [AW-1:0] dpAddr;
    logic [DW-1:0] rdata;
    logic ready;
    logic resp;
    logic busy;
  } fadd_regs_t;

endpackage : fadd_pkg

// [rtl/fadd_scale_cmp.sv]
// signed comparison of the two operand scales
`timescale 1ns/100ps
module fadd_scale_cmp (
  // operand scales
  input wire logic [fadd_pkg::SW-1:0] scaleA,
  input wire logic [fadd_pkg::SW-1:0] scaleB,
  // comparison result
  output fadd_pkg::fadd_cmp_t cmp
);

  logic signed [fadd_pkg::SW:0] bMinusA;
  logic signed [fadd_pkg::SW:0] aMinusB;

  // one extra bit so the difference never wraps
  assign bMinusA = $signed({scaleB[fadd_pkg::SW-1], scaleB})
    - $signed({scaleA[fadd_pkg::SW-1], scaleA});
  assign aMinusB = $signed({scaleA[fadd_pkg::SW-1], scaleA})
    - $signed({scaleB[fadd_pkg::SW-1], scaleB});

  // which operand needs aligning
  assign cmp.aLess = (bMinusA > $signed(fadd_pkg::SCALE_ZERO));
  assign cmp.bLess = (aMinusB > $signed(fadd_pkg::SCALE_ZERO));

  // gaps too wide to close by shifting
  assign cmp.bOverALimit = (bMinusA > $signed(fadd_pkg::GAP_LIMIT));
  assign cmp.aOverBLimit = (aMinusB > $signed(fadd_pkg::GAP_LIMIT));

  // shift count, only meaningful when no limit is exceeded
  assign cmp.gap = cmp.aLess ? bMinusA[fadd_pkg::SW-1:0]
    : aMinusB[fadd_pkg::SW-1:0];

endmodule : fadd_scale_cmp

// [rtl/fadd_datapath.sv]
// floating point align, add, divide and normalize datapath, ahb-lite slave
//
// Function
// RL1: like signs add the magnitudes and raise the like-sign flag.
// RL2: unlike signs on add subtract the magnitudes and raise unlike flag.
// RL3: a scale below b scale selects mantissa a for alignment.
// RL4: b scale below a scale selects mantissa b for alignment.
// RL5: flag when b scale minus a scale exceeds 35.
// RL6: separate flag when a scale minus b scale exceeds 35.
// RL7: exception flag when the scale gap is too large to align.
// RL8: exponent cycle shifts mantissa b right one place per step.
// RL9: larger b scale is copied into the a scale register.
// RL10: subtract overflow is flagged and the result complemented back.
// RL11: carry out of the adder increments the a scale register.
// RL12: zero mantissa a during normalize clears a scale and a sign.
// RL13: negative integer from memory is complemented then incremented.
// RL14: positive single integer load clears buffer bits 00-17.
// RL15: single float load takes the scale from buffer bits 27-35.
// RL16: positive trial subtraction loads the result shifted left into a.
// RL17: negative trial subtraction is dropped and a shifts left.
// RL18: positive first trial subtraction increments the a scale.
// RL19: divide ends with a right shift of a, then swaps a and quotient.
// RL20: integer divide count steps bump a scale and shift quotient left.
// RL21: abort request abandons any exponent, function or normalize cycle.
// RL22: divide by zero is detected and reported as abnormal divide.
// RL23: normalize is done once bit 01 of mantissa a is one.
// RL24: normalize preloads the shift counter with octal 43.
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module fadd_datapath (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [fadd_pkg::DW-1:0] hwdata,
  input wire logic hready,
  output logic [fadd_pkg::DW-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // datapath activity
  output logic busy
);

  fadd_pkg::fadd_regs_t stFf;
  fadd_pkg::fadd_regs_t nxtSt;
  fadd_pkg::fadd_cmp_t cmp;

  // scale comparison feeds the add/subtract start decision
  fadd_scale_cmp u_cmp (
    .scaleA(stFf.scaleA),
    .scaleB(stFf.scaleB),
    .cmp(cmp)
  );

  // read view of the registers, zero above the narrow fields
  function automatic logic [fadd_pkg::DW-1:0] readWord(
    input fadd_pkg::fadd_regs_t r,
    input logic [fadd_pkg::AW-1:0] a
  );
    logic [fadd_pkg::DW-1:0] w;
    w = '0;
    case (a)
      fadd_pkg::OFS_CTRL: begin
        w[fadd_pkg::CTL_OP_MSB:fadd_pkg::CTL_OP_LSB] = r.op;
        w[fadd_pkg::CTL_SINGLE] = r.single;
      end
      fadd_pkg::OFS_STAT: begin
        w[fadd_pkg::STAT_BUSY] = r.busy;
        w[fadd_pkg::STAT_FLAGS_LSB +: $bits(fadd_pkg::fadd_flags_t)] =
          r.flags;
      end
      fadd_pkg::OFS_MAHI: w[fadd_pkg::HW-1:0] = r.mantA[fadd_pkg::MW-1:
        fadd_pkg::HW];
      fadd_pkg::OFS_MALO: w[fadd_pkg::HW-1:0] = r.mantA[fadd_pkg::HW-1:0];
      fadd_pkg::OFS_MBHI: w[fadd_pkg::HW-1:0] = r.mantB[fadd_pkg::MW-1:
        fadd_pkg::HW];
      fadd_pkg::OFS_MBLO: w[fadd_pkg::HW-1:0] = r.mantB[fadd_pkg::HW-1:0];
      fadd_pkg::OFS_MQHI: w[fadd_pkg::HW-1:0] = r.quot[fadd_pkg::MW-1:
        fadd_pkg::HW];
      fadd_pkg::OFS_MQLO: w[fadd_pkg::HW-1:0] = r.quot[fadd_pkg::HW-1:0];
      fadd_pkg::OFS_SCALE: begin
        w[fadd_pkg::SC_A_LSB +: fadd_pkg::SW] = r.scaleA;
        w[fadd_pkg::SC_B_LSB +: fadd_pkg::SW] = r.scaleB;
      end
      fadd_pkg::OFS_SIGN: begin
        w[fadd_pkg::SG_A] = r.signA;
        w[fadd_pkg::SG_B] = r.signB;
      end
      fadd_pkg::OFS_BUFHI: w[fadd_pkg::HW-1:0] = r.membuf[fadd_pkg::MW-1:
        fadd_pkg::HW];
      fadd_pkg::OFS_BUFLO: w[fadd_pkg::HW-1:0] = r.membuf[fadd_pkg::HW-1:0];
      default: w = '0;
    endcase
    return w;
  endfunction : readWord

  // whole next-state computation in one place
  always_comb begin
    fadd_pkg::fadd_op_t cmdOp;
    logic addrPhase;
    logic start;
    logic abort;
    logic idle;
    logic effSignB;
    logic negInt;
    logic [fadd_pkg::MW-1:0] word;
    logic [fadd_pkg::MW:0] sum;
    logic [fadd_pkg::MW:0] dif;
    nxtSt = stFf;
    cmdOp = fadd_pkg::fadd_op_t'(
      hwdata[fadd_pkg::CTL_OP_MSB:fadd_pkg::CTL_OP_LSB]);
    addrPhase = hsel && htrans[1] && hready
      && (hsize == fadd_pkg::SIZE_WORD);
    start = 1'b0;
    abort = 1'b0;
    idle = (stFf.state == fadd_pkg::ST_IDLE);
    effSignB = stFf.signB ^ (cmdOp == fadd_pkg::OP_SUB);
    negInt = 1'b0;
    word = stFf.membuf;
    sum = {1'b0, stFf.mantA} + {1'b0, stFf.mantB};
    dif = {1'b0, stFf.mantA} - {1'b0, stFf.mantB};

    // command register; a start while busy is dropped
    if (stFf.dpWrite && stFf.dpAddr == fadd_pkg::OFS_CTRL) begin
      abort = hwdata[fadd_pkg::CTL_ABORT];
      start = idle && !abort;
    end

    // operand registers only change while idle
    if (stFf.dpWrite && idle) begin
      case (stFf.dpAddr)
        fadd_pkg::OFS_MAHI:
          nxtSt.mantA[fadd_pkg::MW-1:fadd_pkg::HW] = hwdata[fadd_pkg::HW-1:0];
        fadd_pkg::OFS_MALO:
          nxtSt.mantA[fadd_pkg::HW-1:0] = hwdata[fadd_pkg::HW-1:0];
        fadd_pkg::OFS_MBHI:
          nxtSt.mantB[fadd_pkg::MW-1:fadd_pkg::HW] = hwdata[fadd_pkg::HW-1:0];
        fadd_pkg::OFS_MBLO:
          nxtSt.mantB[fadd_pkg::HW-1:0] = hwdata[fadd_pkg::HW-1:0];
        fadd_pkg::OFS_MQHI:
          nxtSt.quot[fadd_pkg::MW-1:fadd_pkg::HW] = hwdata[fadd_pkg::HW-1:0];
        fadd_pkg::OFS_MQLO:
          nxtSt.quot[fadd_pkg::HW-1:0] = hwdata[fadd_pkg::HW-1:0];
        fadd_pkg::OFS_SCALE: begin
          nxtSt.scaleA = hwdata[fadd_pkg::SC_A_LSB +: fadd_pkg::SW];
          nxtSt.scaleB = hwdata[fadd_pkg::SC_B_LSB +: fadd_pkg::SW];
        end
        fadd_pkg::OFS_SIGN: begin
          nxtSt.signA = hwdata[fadd_pkg::SG_A];
          nxtSt.signB = hwdata[fadd_pkg::SG_B];
        end
        fadd_pkg::OFS_BUFHI:
          nxtSt.membuf[fadd_pkg::MW-1:fadd_pkg::HW] =
            hwdata[fadd_pkg::HW-1:0];
        fadd_pkg::OFS_BUFLO:
          nxtSt.membuf[fadd_pkg::HW-1:0] = hwdata[fadd_pkg::HW-1:0];
        default: ;
      endcase
    end

    // sequencer: exponent, function and normalize cycles
    case (stFf.state)
      fadd_pkg::ST_IDLE: begin
        if (start) begin
          nxtSt.op = cmdOp;
          nxtSt.single = hwdata[fadd_pkg::CTL_SINGLE];
          nxtSt.flags = '0;
          case (cmdOp)
            fadd_pkg::OP_ADD, fadd_pkg::OP_SUB: begin
              nxtSt.signB = effSignB;
              nxtSt.flags.likeAdd = (stFf.signA == effSignB); // [RL1]
              nxtSt.flags.unlikeAdd = (stFf.signA != effSignB); // [RL2]
              nxtSt.flags.bOverALimit = cmp.bOverALimit; // [RL5]
              nxtSt.flags.aOverBLimit = cmp.aOverBLimit; // [RL6]
              if (cmp.bOverALimit || cmp.aOverBLimit) begin
                // no sensible alignment exists; mantissas and scales stay untouched, sign b keeps its subtract flip
                nxtSt.flags.scaleGapException = 1'b1; // [RL7]
              end else begin
                nxtSt.cnt = cmp.gap;
                nxtSt.state = fadd_pkg::ST_EXP;
                nxtSt.flags.shiftBForMatch = cmp.bLess; // [RL4]
                if (cmp.aLess) begin
                  // swap so the shifter only ever works on mantissa b
                  nxtSt.flags.shiftAForMatch = 1'b1; // [RL3]
                  nxtSt.mantA = stFf.mantB;
                  nxtSt.mantB = stFf.mantA;
                  nxtSt.signA = effSignB;
                  nxtSt.signB = stFf.signA;
                  nxtSt.scaleA = stFf.scaleB; // [RL9]
                end
              end
            end
            fadd_pkg::OP_DIV: begin
              if (stFf.mantB == fadd_pkg::MANT_ZERO) begin
                nxtSt.flags.divZero = 1'b1; // [RL22]
              end else begin
                nxtSt.scaleA = stFf.scaleA - stFf.scaleB;
                nxtSt.signA = stFf.signA ^ stFf.signB;
                nxtSt.quot = fadd_pkg::MANT_ZERO;
                nxtSt.cnt = fadd_pkg::DIV_STEPS;
                nxtSt.first = 1'b1;
                nxtSt.state = fadd_pkg::ST_FUN;
              end
            end
            fadd_pkg::OP_IDIV: begin
              if (stFf.mantB == fadd_pkg::MANT_ZERO) begin
                nxtSt.flags.divZero = 1'b1; // [RL22]
              end else begin
                nxtSt.quot = stFf.mantA;
                nxtSt.scaleA = fadd_pkg::SCALE_ZERO;
                nxtSt.signA = stFf.signA ^ stFf.signB;
                nxtSt.cnt = fadd_pkg::NORM_PRELOAD;
                nxtSt.state = fadd_pkg::ST_EXP;
              end
            end
            fadd_pkg::OP_LDINT: begin
              // double words carry their sign in the top bit
              negInt = word[fadd_pkg::TOP_BIT];
              if (hwdata[fadd_pkg::CTL_SINGLE]) begin
                negInt = word[fadd_pkg::HALF_SIGN];
                // upper half cleared for positive, filled for negative
                word[fadd_pkg::MW-1:fadd_pkg::HW] = {fadd_pkg::HW{negInt}};
                nxtSt.membuf = word; // [RL14]
              end
              nxtSt.mantB = word;
              nxtSt.signB = negInt;
              if (negInt) begin
                nxtSt.state = fadd_pkg::ST_EXP;
              end
            end
            fadd_pkg::OP_LDFLT: begin
              nxtSt.scaleB = word[fadd_pkg::SW-1:0]; // [RL15]
              nxtSt.signB = word[fadd_pkg::TOP_BIT];
              nxtSt.mantB = {1'b0, word[fadd_pkg::MW-2:fadd_pkg::SW],
                {fadd_pkg::SW{1'b0}}};
            end
            fadd_pkg::OP_NORM: begin
              nxtSt.cnt = fadd_pkg::NORM_PRELOAD; // [RL24]
              nxtSt.state = fadd_pkg::ST_NOR;
            end
            default: ;
          endcase
        end
      end
      fadd_pkg::ST_EXP: begin
        case (stFf.op)
          fadd_pkg::OP_ADD, fadd_pkg::OP_SUB: begin
            if (stFf.cnt == fadd_pkg::SCALE_ZERO) begin
              nxtSt.state = fadd_pkg::ST_FUN;
            end else begin
              nxtSt.mantB = stFf.mantB >> 1; // [RL8]
              nxtSt.cnt = stFf.cnt - fadd_pkg::SCALE_ONE;
            end
          end
          fadd_pkg::OP_IDIV: begin
            if (stFf.quot[fadd_pkg::TOP_BIT] || stFf.quot[fadd_pkg::LEAD_BIT]
                || stFf.cnt == fadd_pkg::SCALE_ZERO) begin
              nxtSt.mantA = stFf.quot;
              nxtSt.quot = fadd_pkg::MANT_ZERO;
              nxtSt.cnt = fadd_pkg::DIV_STEPS;
              nxtSt.first = 1'b1;
              nxtSt.state = fadd_pkg::ST_FUN;
            end else begin
              nxtSt.scaleA = stFf.scaleA + fadd_pkg::SCALE_ONE; // [RL20]
              nxtSt.quot = stFf.quot << 1; // [RL20]
              nxtSt.cnt = stFf.cnt - fadd_pkg::SCALE_ONE;
            end
          end
          fadd_pkg::OP_LDINT: begin
            nxtSt.mantB = ~stFf.mantB; // [RL13]
            nxtSt.state = fadd_pkg::ST_FUN;
          end
          default: nxtSt.state = fadd_pkg::ST_IDLE;
        endcase
      end
      fadd_pkg::ST_FUN: begin
        case (stFf.op)
          fadd_pkg::OP_ADD, fadd_pkg::OP_SUB: begin
            if (stFf.flags.likeAdd) begin
              if (sum[fadd_pkg::MW]) begin
                // carry kept by a right shift, scale follows
                nxtSt.mantA = sum[fadd_pkg::MW:1];
                nxtSt.scaleA = stFf.scaleA + fadd_pkg::SCALE_ONE; // [RL11]
                nxtSt.flags.carryScaleBump = 1'b1; // [RL11]
              end else begin
                nxtSt.mantA = sum[fadd_pkg::MW-1:0]; // [RL1]
              end
            end else if (dif[fadd_pkg::MW]) begin
              nxtSt.flags.subOverflow = 1'b1; // [RL10]
              nxtSt.mantA = ~dif[fadd_pkg::MW-1:0] + fadd_pkg::MANT_ONE;
              nxtSt.signA = ~stFf.signA; // [RL10]
            end else begin
              nxtSt.mantA = dif[fadd_pkg::MW-1:0]; // [RL2]
            end
            nxtSt.cnt = fadd_pkg::NORM_PRELOAD; // [RL24]
            nxtSt.state = fadd_pkg::ST_NOR;
          end
          fadd_pkg::OP_DIV, fadd_pkg::OP_IDIV: begin
            if (!dif[fadd_pkg::MW]) begin
              nxtSt.mantA = dif[fadd_pkg::MW-1:0] << 1; // [RL16]
              nxtSt.quot = {stFf.quot[fadd_pkg::MW-2:0], 1'b1};
              if (stFf.first) begin
                nxtSt.scaleA = stFf.scaleA + fadd_pkg::SCALE_ONE; // [RL18]
              end
            end else begin
              nxtSt.mantA = stFf.mantA << 1; // [RL17]
              nxtSt.quot = {stFf.quot[fadd_pkg::MW-2:0], 1'b0};
            end
            nxtSt.first = 1'b0;
            nxtSt.cnt = stFf.cnt - fadd_pkg::SCALE_ONE;
            if (stFf.cnt == fadd_pkg::SCALE_ONE) begin
              nxtSt.state = fadd_pkg::ST_DVEND;
            end
          end
          fadd_pkg::OP_LDINT: begin
            nxtSt.mantB = stFf.mantB + fadd_pkg::MANT_ONE; // [RL13]
            nxtSt.state = fadd_pkg::ST_IDLE;
          end
          default: nxtSt.state = fadd_pkg::ST_IDLE;
        endcase
      end
      fadd_pkg::ST_NOR: begin
        if (stFf.mantA == fadd_pkg::MANT_ZERO) begin
          nxtSt.scaleA = fadd_pkg::SCALE_ZERO; // [RL12]
          nxtSt.signA = 1'b0; // [RL12]
          nxtSt.flags.zeroResultClear = 1'b1;
          nxtSt.state = fadd_pkg::ST_IDLE;
        end else if (stFf.mantA[fadd_pkg::TOP_BIT]
            || stFf.mantA[fadd_pkg::LEAD_BIT]) begin
          nxtSt.flags.leadingOneFound = 1'b1; // [RL23]
          nxtSt.state = fadd_pkg::ST_IDLE;
        end else if (stFf.cnt == fadd_pkg::SCALE_ZERO) begin
          // counter bounds the shifts even on odd data
          nxtSt.state = fadd_pkg::ST_IDLE; // [RL24]
        end else begin
          nxtSt.mantA = stFf.mantA << 1;
          nxtSt.scaleA = stFf.scaleA - fadd_pkg::SCALE_ONE;
          nxtSt.cnt = stFf.cnt - fadd_pkg::SCALE_ONE;
        end
      end
      fadd_pkg::ST_DVEND: begin
        nxtSt.mantA = stFf.mantA >> 1; // [RL19]
        nxtSt.state = fadd_pkg::ST_DVSWP;
      end
      fadd_pkg::ST_DVSWP: begin
        nxtSt.mantA = stFf.quot; // [RL19]
        nxtSt.quot = stFf.mantA;
        nxtSt.state = fadd_pkg::ST_IDLE;
      end
      default: nxtSt.state = fadd_pkg::ST_IDLE;
    endcase

    // abort wins over whatever the sequencer chose
    if (abort && !idle) begin
      nxtSt.state = fadd_pkg::ST_IDLE; // [RL21]
      nxtSt.flags.phaseAborted = 1'b1; // [RL21]
    end
    nxtSt.busy = (nxtSt.state != fadd_pkg::ST_IDLE);

    // bus: zero wait, read taken from post-write view so no stale data
    nxtSt.dpWrite = addrPhase && hwrite;
    nxtSt.dpAddr = haddr[fadd_pkg::AW-1:0];
    nxtSt.rdata = (addrPhase && !hwrite)
      ? readWord(nxtSt, haddr[fadd_pkg::AW-1:0]) : '0;
    nxtSt.ready = 1'b1;
    nxtSt.resp = 1'b0;
  end

  // single state register
  always_ff @(posedge clk) begin
    if (rst) begin
      stFf <= '0;
      stFf.state <= fadd_pkg::ST_IDLE;
      stFf.op <= fadd_pkg::OP_NOP;
      stFf.ready <= 1'b1;
    end else begin
      stFf <= nxtSt;
    end
  end

  // outputs straight from the state register
  assign hrdata = stFf.rdata;
  assign hreadyout = stFf.ready;
  assign hresp = stFf.resp;
  assign busy = stFf.busy;

endmodule : fadd_datapath

// [verification/fadd_datapath_assertions.sv]
// port checker for the datapath register bus and busy flag
`timescale 1ns/100ps
module fadd_assert_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus request
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [fadd_pkg::DW-1:0] hwdata,
  input wire logic hready,
  // slave answer and activity
  input wire logic [fadd_pkg::DW-1:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic busy
);
  logic take;
  logic rdPh_ff, ctlPh_ff, badPh_ff, ctlD_ff;
  logic [6:0] runCnt_ff;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  assign take = hsel && htrans[1] && hready && hsize == fadd_pkg::SIZE_WORD;
  // data phase trackers; run counter saturates so it cannot wrap
  always_ff @(posedge clk) begin
    if (rst) begin
      rdPh_ff <= 1'b0;
      ctlPh_ff <= 1'b0;
      badPh_ff <= 1'b0;
      ctlD_ff <= 1'b0;
      runCnt_ff <= 7'h00;
    end else begin
      rdPh_ff <= take && !hwrite;
      ctlPh_ff <= take && hwrite && haddr[7:0] == fadd_pkg::OFS_CTRL;
      badPh_ff <= take && !hwrite && haddr[7:0] > fadd_pkg::OFS_BUFLO;
      ctlD_ff <= ctlPh_ff;
      runCnt_ff <= busy ? runCnt_ff + 7'(runCnt_ff != 7'h7f) : 7'h00;
    end
  end
  AST_READY: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("slave answered with an error response");
  AST_RD_QUIET: assert property (!rdPh_ff |-> hrdata == '0)
    else $error("read data driven outside a read data phase");
  AST_UNMAPPED: assert property (badPh_ff |-> hrdata == '0)
    else $error("unmapped offset read back nonzero");
  AST_ABORT: assert property (
    ctlPh_ff && hwdata[fadd_pkg::CTL_ABORT] && busy |-> ##[1:2] !busy)
    else $error("abort did not end the running sequence");
  AST_BUSY_CAUSE: assert property (
    $rose(busy) |-> $past(ctlD_ff) || $past(ctlPh_ff))
    else $error("busy rose without a command write");
  AST_NOP_IDLE: assert property (
    ctlPh_ff && hwdata[2:0] == 3'h0 && !busy |=> !busy [*3])
    else $error("no-op command started a sequence");
  AST_BOUND: assert property (runCnt_ff != 7'h7f)
    else $error("sequence ran past its shift bound");
endmodule : fadd_assert_chk

bind fadd_datapath fadd_assert_chk u_fadd_assert_chk (.clk, .rst, .hsel,
  .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
  .hresp, .busy);

// [verification/tb_fadd_datapath.sv]
// self-checking bench for the float datapath over its ahb-lite port
`timescale 1ns/100ps
`define CK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_fadd_datapath;
  logic clk = 0, rst = 1, hsel = 1, hwrite = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rv;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic hready, hresp, busy;
  int fails = 0, checked = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  fadd_datapath u_fadd_datapath (.clk, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
    .busy);
  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // bounded wait for ready; a hang ends the run
  task automatic waitRdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) begin
      fails++;
      report_and_stop();
    end
  endtask : waitRdy
  // one single word transfer; read data lands in rv
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rv = hrdata;
  endtask : xfer
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  // command start, then bounded wait until the sequence is over
  task automatic run(input logic [2:0] op, input logic s);
    int n;
    n = 0;
    xfer(1'b1, fadd_pkg::OFS_CTRL, {28'h000_0000, s, op});
    repeat (3) @(posedge clk);
    while (busy !== 1'b0 && n < 300) begin
      n++;
      @(posedge clk);
    end
    if (n >= 300) begin
      fails++;
      report_and_stop();
    end
    rd(fadd_pkg::OFS_STAT);
  endtask : run
  task automatic ld(input logic [35:0] ma, mb, input logic [31:0] sc, sg);
    xfer(1'b1, fadd_pkg::OFS_MAHI, {14'h0000, ma[35:18]});
    xfer(1'b1, fadd_pkg::OFS_MALO, {14'h0000, ma[17:0]});
    xfer(1'b1, fadd_pkg::OFS_MBHI, {14'h0000, mb[35:18]});
    xfer(1'b1, fadd_pkg::OFS_MBLO, {14'h0000, mb[17:0]});
    xfer(1'b1, fadd_pkg::OFS_SCALE, sc);
    xfer(1'b1, fadd_pkg::OFS_SIGN, sg);
  endtask : ld
  task automatic s_add();
    ld(36'h4_0000_0000, 36'h4_0000_0000, 32'h0001_0002, 32'h0000_0000);
    run(3'h1, 1'b0);
    `CK("like", 1'b1, rv[1])
    `CK("alignB", 1'b1, rv[4])
    rd(fadd_pkg::OFS_MAHI);
    `CK("sum", 32'h0001_8000, rv)
    ld(36'h4_0000_0000, 36'h4_0000_0000, 32'h0002_0001, 32'h0000_0000);
    run(3'h1, 1'b0);
    `CK("alignA", 1'b1, rv[3])
    rd(fadd_pkg::OFS_SCALE);
    `CK("scaleA", 9'h002, rv[8:0])
  endtask : s_add
  task automatic s_unlike();
    ld(36'h4_0000_0000, 36'h2_0000_0000, 32'h0001_0001, 32'h0000_0002);
    run(3'h1, 1'b0);
    `CK("unlike", 1'b1, rv[2])
    rd(fadd_pkg::OFS_MAHI);
    `CK("diff", 32'h0001_0000, rv)
    ld(36'h2_0000_0000, 36'h4_0000_0000, 32'h0001_0001, 32'h0000_0002);
    run(3'h1, 1'b0);
    `CK("borrow", 1'b1, rv[8])
    rd(fadd_pkg::OFS_SIGN);
    `CK("signA", 1'b1, rv[0])
  endtask : s_unlike
  // gap of 36 either way is refused, 35 is not
  task automatic s_gap();
    ld(36'h4_0000_0000, 36'h4_0000_0000, 32'h0024_0000, 32'h0000_0000);
    run(3'h1, 1'b0);
    `CK("bOverA", 2'h3, {rv[7], rv[5]})
    ld(36'h4_0000_0000, 36'h4_0000_0000, 32'h0000_0024, 32'h0000_0000);
    run(3'h1, 1'b0);
    `CK("aOverB", 2'h3, {rv[7], rv[6]})
    ld(36'h4_0000_0000, 36'h4_0000_0000, 32'h0000_0023, 32'h0000_0000);
    run(3'h1, 1'b0);
    `CK("gap35", 3'h0, {rv[7], rv[6], rv[5]})
  endtask : s_gap
  task automatic s_norm();
    ld(36'h0_0000_0000, 36'h4_0000_0000, 32'h0000_0005, 32'h0000_0001);
    run(3'h7, 1'b0);
    `CK("zeroClr", 1'b1, rv[10])
    rd(fadd_pkg::OFS_SIGN);
    `CK("zeroSign", 1'b0, rv[0])
    ld(36'h0_4000_0000, 36'h4_0000_0000, 32'h0000_0005, 32'h0000_0000);
    run(3'h7, 1'b0);
    `CK("lead", 1'b1, rv[12])
    rd(fadd_pkg::OFS_MAHI);
    `CK("normed", 32'h0001_0000, rv)
  endtask : s_norm
  task automatic s_div();
    ld(36'h4_0000_0000, 36'h0_0000_0000, 32'h0000_0000, 32'h0000_0000);
    run(3'h3, 1'b0);
    `CK("divZero", 1'b1, rv[11])
    ld(36'h4_0000_0000, 36'h4_0000_0000, 32'h0000_0000, 32'h0000_0000);
    run(3'h3, 1'b0);
    rd(fadd_pkg::OFS_MAHI);
    `CK("quot", 32'h0002_0000, rv)
    rd(fadd_pkg::OFS_SCALE);
    `CK("divScale", 9'h001, rv[8:0])
    xfer(1'b1, fadd_pkg::OFS_CTRL, 32'h0000_0003);
    repeat (4) @(posedge clk);
    `CK("busy", 1'b1, busy)
    xfer(1'b1, fadd_pkg::OFS_CTRL, 32'h0000_0010);
    rd(fadd_pkg::OFS_STAT);
    `CK("aborted", 2'h2, rv[13:12])
    ld(36'h0_0000_0001, 36'h4_0000_0000, 32'h0000_0000, 32'h0000_0000);
    run(3'h4, 1'b0);
    rd(fadd_pkg::OFS_SCALE);
    `CK("idivScale", 9'h023, rv[8:0])
  endtask : s_div
  task automatic s_load();
    xfer(1'b1, fadd_pkg::OFS_BUFHI, 32'h0001_0000);
    xfer(1'b1, fadd_pkg::OFS_BUFLO, 32'h0000_0005);
    run(3'h6, 1'b1);
    rd(fadd_pkg::OFS_SCALE);
    `CK("scaleB", 9'h005, rv[24:16])
    xfer(1'b1, fadd_pkg::OFS_BUFHI, 32'h0003_ffff);
    run(3'h5, 1'b1);
    rd(fadd_pkg::OFS_BUFHI);
    `CK("upperClr", 32'h0000_0000, rv)
    xfer(1'b1, fadd_pkg::OFS_BUFHI, 32'h0002_0000);
    run(3'h5, 1'b0);
    rd(fadd_pkg::OFS_MBLO);
    `CK("negInt", 32'h0003_fffb, rv)
    ld(36'h8_0000_0000, 36'h8_0000_0000, 32'h0000_0000, 32'h0000_0000);
    run(3'h1, 1'b0);
    `CK("carry", 1'b1, rv[9])
  endtask : s_load
  // reset, then each scenario in turn
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(fadd_pkg::OFS_STAT);
    `CK("statRst", 32'h0000_0000, rv)
    xfer(1'b1, 8'h30, 32'hffff_ffff);
    rd(8'h30);
    `CK("unmapped", 32'h0000_0000, rv)
    s_add();
    s_unlike();
    s_gap();
    s_norm();
    s_div();
    s_load();
    report_and_stop();
  end
endmodule : tb_fadd_datapath
